// *** design/rlsup_link.sv ***
// Link start-up state machines and user message ports with an APB register slave
`timescale 1ns/1ps
module rlsup_link #(
    parameter int M_MG = 5,
    parameter int N_MG = 4,
    parameter int K_MG = 5,
    parameter int RATE_INDEX = 1,
    parameter int BLOCK_SIZE = 16,
    parameter int SYNC_T = 4,
    parameter int UNSYNCHRONIZED_STATE_T = 4,
    parameter int FRAME_SYNC_T = 4,
    parameter int FRAME_UNSYNCHRONIZED_STATE_T = 4
) (
    // System clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Line status
    input wire logic loss_of_signal,
    // Receive lane from the coding layer
    input wire logic [15:0] rx_lane_data,
    input wire logic [1:0] rx_lane_k,
    input wire logic [1:0] rx_lane_cv,
    // Transmit lane to the coding layer
    output logic [15:0] tx_lane_data,
    output logic [1:0] tx_lane_k,
    // Receive user port
    output logic [19:0] rx_payload_msg_bus,
    output logic [1:0] rx_payload_msg_valid,
    output logic [20:0] rx_payload_msg_number,
    output logic [1:0] rx_frame_start_flag,
    output logic [19:0] rx_ctl_msg_bus,
    output logic [1:0] rx_ctl_msg_valid,
    // Transmit user port
    input wire logic [17:0] tx_payload_msg_bus,
    input wire logic tx_msg_supplied,
    output logic [1:0] tx_payload_msg_request,
    output logic [20:0] tx_payload_msg_number,
    output logic [1:0] tx_frame_start_flag
);
    import rlsup_pkg::*;

    localparam int MSG_AREA = M_MG * MSG_BYTES;
    localparam int GLEN = MSG_AREA + K_MG;
    localparam int NGRP = N_MG * RATE_INDEX;
    localparam logic [12:0] MSG_AREA_W = 13'(MSG_AREA);
    localparam logic [12:0] GLEN_M1 = 13'(GLEN - 1);
    localparam logic [13:0] NGRP_M1 = 14'(NGRP - 1);
    localparam logic [15:0] BLK_LAST = 16'(BLOCK_SIZE - 2);
    localparam logic [15:0] SYNC_W = 16'(SYNC_T);
    localparam logic [15:0] UNSYNCHRONIZED_STATE_W = 16'(UNSYNCHRONIZED_STATE_T);
    localparam logic [15:0] FSYNC_W = 16'(FRAME_SYNC_T);
    localparam logic [15:0] FUNSYNC_W = 16'(FRAME_UNSYNCHRONIZED_STATE_T);
    localparam logic [4:0] KMG_W = 5'(K_MG);

    // ******************************
    // Parameter checks
    // ******************************
    generate
        if (M_MG < 4 || M_MG > 255 || K_MG < 1 || K_MG > 19) begin : g_bad_group
            $error("Group shape out of range");
        end
        if (!(RATE_INDEX == 1 || RATE_INDEX == 2 || RATE_INDEX == 4)) begin : g_bad_rate
            $error("Rate index must be 1, 2 or 4");
        end
        if (NGRP < 4 || NGRP > 16383 || ((NGRP * GLEN) % 2) != 0) begin : g_bad_frame
            $error("Frame must hold 4 to 16383 groups and an even byte count");
        end
        if (BLOCK_SIZE < 2 || BLOCK_SIZE > 65534 || (BLOCK_SIZE % 2) != 0) begin : g_bad_blk
            $error("Block size must be even, 2 to 65534");
        end
        if (SYNC_T < 1 || UNSYNCHRONIZED_STATE_T < 1 || FRAME_SYNC_T < 1 || FRAME_UNSYNCHRONIZED_STATE_T < 1) begin : g_thr
            $error("Thresholds must be at least one");
        end
    endgenerate

    // ******************************
    // Frame position helpers
    // ******************************
    function automatic rlsup_pos_type step_pos(input rlsup_pos_type p);
        rlsup_pos_type n;
        n = p;
        if (p.gpos == GLEN_M1) begin
            n.gpos = '0;
            n.mpos = '0;
            n.mig = '0;
            n.grp = (p.grp == NGRP_M1) ? '0 : p.grp + 14'h0001;
        end else begin
            n.gpos = p.gpos + 13'h0001;
            if (p.mpos == MPOS_LAST) begin
                n.mpos = '0;
                n.mig = p.mig + 8'h01;
            end else begin
                n.mpos = p.mpos + 5'h01;
            end
        end
        return n;
    endfunction

    function automatic logic msg_start(input rlsup_pos_type p);
        return (p.gpos < MSG_AREA_W) && (p.mpos == 5'h00);
    endfunction

    function automatic logic frame_start(input rlsup_pos_type p);
        return (p.grp == 14'h0000) && (p.gpos == 13'h0000);
    endfunction

    function automatic logic [1:0] byte_class(input rlsup_pos_type p);
        if (p.gpos >= MSG_AREA_W) begin
            return (p.grp == NGRP_M1) ? CLS_K287 : CLS_K285;
        end
        return (p.mig == CTL_MSG_INDEX) ? CLS_FILL : CLS_DATA;
    endfunction

    // Message area accepts data or fill; idle area accepts the three idle codes
    function automatic logic byte_ok(input rlsup_pos_type p, input logic k, input logic [7:0] d);
        if (p.gpos < MSG_AREA_W) begin
            return !k || (d == K30_7_BYTE);
        end
        return k && (d == K28_5_BYTE || d == K28_7_BYTE || d == K30_7_BYTE);
    endfunction

    // ******************************
    // APB register slave
    // ******************************
    logic [1:0] ctrl, next_ctrl;
    logic [31:0] delta, next_delta;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic delta_wr;
    rlsup_tx_state_type tx_state, next_tx_state;
    rlsup_rx_state_type rx_state, next_rx_state;

    always_comb begin
        logic acc;
        acc = psel && penable && !pready;
        next_ctrl = ctrl;
        next_delta = delta;
        next_prdata = 32'h0000_0000;
        next_pready = acc;
        next_pslverr = 1'b0;
        delta_wr = 1'b0;
        if (acc) begin
            unique case (paddr)
                CTRL_OFFSET: begin
                    if (pwrite) next_ctrl = pwdata[1:0];
                    next_prdata = {30'h0000_0000, ctrl};
                end
                DELTA_OFFSET: begin
                    if (pwrite) begin
                        next_delta = pwdata;
                        delta_wr = 1'b1;
                    end
                    next_prdata = delta;
                end
                STATUS_OFFSET: begin
                    next_prdata[STATUS_TX_LSB +: 3] = tx_state;
                    next_prdata[STATUS_RX_LSB +: 4] = rx_state;
                    next_prdata[STATUS_LOS_BIT] = loss_of_signal;
                end
                default: next_pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
            delta <= DELTA_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            delta <= next_delta;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ******************************
    // Transmitter
    // ******************************
    rlsup_pos_type tx_pos, next_tx_pos;
    logic [3:0] tx_cls1, next_tx_cls1, tx_cls2;
    logic [1:0] next_tx_req, next_tx_fs;
    logic [20:0] tx_count, next_tx_count, next_tx_number;
    logic [15:0] next_tx_lane_data;
    logic [1:0] next_tx_lane_k;

    always_comb begin
        logic run_ok;
        rlsup_pos_type lo;
        run_ok = ctrl[CTRL_TX_ENABLE_BIT] && (!ctrl[CTRL_LOS_GATE_BIT] || loss_of_signal);
        lo = step_pos(tx_pos);
        next_tx_state = tx_state;
        next_tx_pos = tx_pos;
        next_tx_req = 2'h0;
        next_tx_fs = 2'h0;
        next_tx_count = tx_count;
        next_tx_number = tx_payload_msg_number;
        next_tx_cls1 = {CLS_FILL, CLS_FILL};
        unique case (tx_state)
            TX_OFF: begin
                if (run_ok) next_tx_state = TX_IDLE;
            end
            TX_IDLE: begin
                next_tx_cls1 = {CLS_K285, CLS_K285};
                if (!run_ok) begin
                    next_tx_state = TX_OFF;
                end else if (delta_wr) begin
                    next_tx_state = TX_FRAME;
                    next_tx_pos = '0;
                end
            end
            TX_FRAME: begin
                if (!run_ok) begin
                    next_tx_state = TX_OFF;
                end else begin
                    next_tx_pos = step_pos(lo);
                    next_tx_cls1 = {byte_class(tx_pos), byte_class(lo)};
                    next_tx_fs = {frame_start(lo), frame_start(tx_pos)};
                    if (frame_start(tx_pos)) next_tx_count = '0;
                    next_tx_req[0] = msg_start(tx_pos) && byte_class(tx_pos) == CLS_DATA;
                    next_tx_req[1] = msg_start(lo) && byte_class(lo) == CLS_DATA;
                    if (|next_tx_req) begin
                        next_tx_number = next_tx_count;
                        next_tx_count = next_tx_count + 21'h00_0001;
                    end
                end
            end
        endcase
    end

    // Lane builder: user data sampled one cycle after its request
    always_comb begin
        logic [17:0] bus;
        bus = tx_payload_msg_bus;
        next_tx_lane_data = 16'h0000;
        next_tx_lane_k = 2'h0;
        for (int i = 0; i < 2; i++) begin
            logic [1:0] cls;
            logic [7:0] ud;
            // High lane takes the upper class field
            cls = tx_cls2[(1-i)*2 +: 2];
            ud = (i == 0) ? bus[15:8] : bus[7:0];
            unique case (cls)
                CLS_FILL: begin
                    next_tx_lane_data[15-i*8 -: 8] = K30_7_BYTE;
                    next_tx_lane_k[1-i] = 1'b1;
                end
                CLS_K285: begin
                    next_tx_lane_data[15-i*8 -: 8] = K28_5_BYTE;
                    next_tx_lane_k[1-i] = 1'b1;
                end
                CLS_K287: begin
                    next_tx_lane_data[15-i*8 -: 8] = K28_7_BYTE;
                    next_tx_lane_k[1-i] = 1'b1;
                end
                CLS_DATA: begin
                    // Nothing supplied leaves an empty message of fill codes
                    next_tx_lane_data[15-i*8 -: 8] = tx_msg_supplied ? ud : K30_7_BYTE;
                    next_tx_lane_k[1-i] = tx_msg_supplied ? bus[17-i] : 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= TX_OFF;
            tx_pos <= '0;
            tx_cls1 <= {CLS_FILL, CLS_FILL};
            tx_cls2 <= {CLS_FILL, CLS_FILL};
            tx_count <= '0;
            tx_payload_msg_request <= 2'h0;
            tx_payload_msg_number <= '0;
            tx_frame_start_flag <= 2'h0;
            tx_lane_data <= {K30_7_BYTE, K30_7_BYTE};
            tx_lane_k <= 2'h3;
        end else begin
            tx_state <= next_tx_state;
            tx_pos <= next_tx_pos;
            tx_cls1 <= next_tx_cls1;
            tx_cls2 <= tx_cls1;
            tx_count <= next_tx_count;
            tx_payload_msg_request <= next_tx_req;
            tx_payload_msg_number <= next_tx_number;
            tx_frame_start_flag <= next_tx_fs;
            tx_lane_data <= next_tx_lane_data;
            tx_lane_k <= next_tx_lane_k;
        end
    end

    // ******************************
    // Receiver
    // ******************************
    logic [15:0] s1_data, s2_data, next_s2_data;
    logic [1:0] s1_k, s1_cv, s2_k, s2_cv, s2_k287, next_s2_k, next_s2_k287;
    rlsup_pos_type rx_pos, next_rx_pos;
    logic [15:0] blk_cnt, next_blk_cnt, good_blk, next_good_blk, bad_blk, next_bad_blk;
    logic blk_bad, next_blk_bad;
    logic [15:0] good_grp, next_good_grp, bad_grp, next_bad_grp;
    logic grp_bad, next_grp_bad;
    logic [4:0] idle_run, next_idle_run;
    logic [20:0] rx_count, next_rx_count, next_rx_number;
    logic [19:0] next_rx_bus;
    logic [1:0] next_rx_valid, next_rx_cvalid, next_rx_fs;

    // Boundary idle detect and violation replacement
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            next_s2_k287[i] = s1_data[i*8 +: 8] == K28_7_BYTE && s1_k[i] && !s1_cv[i];
            next_s2_data[i*8 +: 8] = s1_cv[i] ? K30_7_BYTE : s1_data[i*8 +: 8];
            next_s2_k[i] = s1_cv[i] | s1_k[i];
        end
    end

    always_comb begin
        rlsup_pos_type lo;
        logic bad_now, blk_end, bad_hi, bad_lo, grp_done, grp_res, in_frame;
        logic [4:0] run;
        lo = step_pos(rx_pos);
        next_rx_state = rx_state;
        next_rx_pos = rx_pos;
        // Block checker runs in every state
        bad_now = blk_bad | (|s2_cv);
        blk_end = blk_cnt == BLK_LAST;
        next_blk_cnt = blk_end ? 16'h0000 : blk_cnt + 16'h0002;
        next_blk_bad = blk_end ? 1'b0 : bad_now;
        next_good_blk = good_blk;
        next_bad_blk = bad_blk;
        if (blk_end) begin
            next_good_blk = bad_now ? 16'h0000 : good_blk + {15'h0000, good_blk != RUN_MAX};
            next_bad_blk = bad_now ? bad_blk + {15'h0000, bad_blk != RUN_MAX} : 16'h0000;
        end
        // Consecutive boundary idles, high byte first
        run = s2_k287[1] ? idle_run + {4'h0, idle_run != KMG_W} : 5'h00;
        run = s2_k287[0] ? run + {4'h0, run != KMG_W} : 5'h00;
        next_idle_run = run;
        // Message group checker
        in_frame = rx_state == RX_WAIT_FRAME_SYNC || rx_state == RX_FRAME_SYNC;
        bad_hi = !byte_ok(rx_pos, s2_k[1], s2_data[15:8]);
        bad_lo = !byte_ok(lo, s2_k[0], s2_data[7:0]);
        grp_done = 1'b0;
        grp_res = 1'b0;
        next_grp_bad = grp_bad | bad_hi | bad_lo;
        if (rx_pos.gpos == GLEN_M1) begin
            grp_done = 1'b1;
            grp_res = grp_bad | bad_hi;
            next_grp_bad = bad_lo;
        end else if (lo.gpos == GLEN_M1) begin
            grp_done = 1'b1;
            grp_res = grp_bad | bad_hi | bad_lo;
            next_grp_bad = 1'b0;
        end
        next_good_grp = good_grp;
        next_bad_grp = bad_grp;
        if (grp_done) begin
            next_good_grp = grp_res ? 16'h0000 : good_grp + {15'h0000, good_grp != RUN_MAX};
            next_bad_grp = grp_res ? bad_grp + {15'h0000, bad_grp != RUN_MAX} : 16'h0000;
        end
        if (in_frame) begin
            next_rx_pos = step_pos(lo);
        end
        unique case (rx_state)
            unsynchronized_state: begin
                if (good_blk >= SYNC_W) next_rx_state = wait_boundary_idles_state;
            end
            wait_boundary_idles_state: begin
                if (bad_blk >= UNSYNCHRONIZED_STATE_W) begin
                    next_rx_state = unsynchronized_state;
                end else if (s2_k287[0] && run == KMG_W) begin
                    // Last idle sits in the low lane, so the frame opens on the high lane
                    next_rx_state = RX_WAIT_FRAME_SYNC;
                    next_rx_pos = '0;
                end
            end
            RX_WAIT_FRAME_SYNC: begin
                if (bad_blk >= UNSYNCHRONIZED_STATE_W) begin
                    next_rx_state = unsynchronized_state;
                end else if (good_grp >= FSYNC_W) begin
                    next_rx_state = RX_FRAME_SYNC;
                end
            end
            RX_FRAME_SYNC: begin
                if (bad_blk >= UNSYNCHRONIZED_STATE_W) begin
                    next_rx_state = unsynchronized_state;
                end else if (bad_grp >= FUNSYNC_W) begin
                    next_rx_state = wait_boundary_idles_state;
                end
            end
        endcase
        if (!in_frame || next_rx_state != rx_state) begin
            next_grp_bad = 1'b0;
            next_good_grp = 16'h0000;
            next_bad_grp = 16'h0000;
        end
        // User side delivery, only while frame synchronized
        next_rx_bus = {s2_cv[1], s2_k[1], s2_cv[0], s2_k[0], s2_data};
        next_rx_valid = 2'h0;
        next_rx_cvalid = 2'h0;
        next_rx_fs = 2'h0;
        next_rx_count = rx_count;
        next_rx_number = rx_payload_msg_number;
        if (rx_state == RX_FRAME_SYNC) begin
            next_rx_fs = {frame_start(lo), frame_start(rx_pos)};
            if (frame_start(rx_pos)) next_rx_count = '0;
            next_rx_valid[0] = msg_start(rx_pos) && rx_pos.mig != CTL_MSG_INDEX;
            next_rx_valid[1] = msg_start(lo) && lo.mig != CTL_MSG_INDEX;
            next_rx_cvalid[0] = msg_start(rx_pos) && rx_pos.mig == CTL_MSG_INDEX;
            next_rx_cvalid[1] = msg_start(lo) && lo.mig == CTL_MSG_INDEX;
            if (|next_rx_valid) begin
                next_rx_number = next_rx_count;
                next_rx_count = next_rx_count + 21'h00_0001;
            end
        end else begin
            next_rx_bus = 20'h0_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_data <= 16'h0000;
            s1_k <= 2'h0;
            s1_cv <= 2'h0;
            s2_data <= 16'h0000;
            s2_k <= 2'h0;
            s2_cv <= 2'h0;
            s2_k287 <= 2'h0;
            rx_state <= unsynchronized_state;
            rx_pos <= '0;
            blk_cnt <= 16'h0000;
            blk_bad <= 1'b0;
            good_blk <= 16'h0000;
            bad_blk <= 16'h0000;
            good_grp <= 16'h0000;
            bad_grp <= 16'h0000;
            grp_bad <= 1'b0;
            idle_run <= 5'h00;
            rx_count <= '0;
            rx_payload_msg_bus <= 20'h0_0000;
            rx_ctl_msg_bus <= 20'h0_0000;
            rx_payload_msg_valid <= 2'h0;
            rx_ctl_msg_valid <= 2'h0;
            rx_payload_msg_number <= '0;
            rx_frame_start_flag <= 2'h0;
        end else begin
            s1_data <= rx_lane_data;
            s1_k <= rx_lane_k;
            s1_cv <= rx_lane_cv;
            s2_data <= next_s2_data;
            s2_k <= next_s2_k;
            s2_cv <= s1_cv;
            s2_k287 <= next_s2_k287;
            rx_state <= next_rx_state;
            rx_pos <= next_rx_pos;
            blk_cnt <= next_blk_cnt;
            blk_bad <= next_blk_bad;
            good_blk <= next_good_blk;
            bad_blk <= next_bad_blk;
            good_grp <= next_good_grp;
            bad_grp <= next_bad_grp;
            grp_bad <= next_grp_bad;
            idle_run <= next_idle_run;
            rx_count <= next_rx_count;
            rx_payload_msg_bus <= next_rx_bus;
            rx_ctl_msg_bus <= next_rx_bus;
            rx_payload_msg_valid <= next_rx_valid;
            rx_ctl_msg_valid <= next_rx_cvalid;
            rx_payload_msg_number <= next_rx_number;
            rx_frame_start_flag <= next_rx_fs;
        end
    end

endmodule // rlsup_link

// *** design/rlsup_pkg.sv ***
// Constants, types and register map of the serial link start-up and user port block
// What this block does
// - After reset transmitter sends continuous fill K30.7
// - Enable, gated by signal loss, gives K28.5 idle
// - Offset delay write starts frame transmission
// - Receiver starts unsynchronized, passes nothing, checks blocks
// - Enough good blocks: wait for boundary idles
// - Enough boundary idles: wait for frame sync
// - Enough good groups: synchronized, messages delivered
// - Every user message is nineteen bytes; payload messages numbered, control messages not
// - Receive bus: first byte high, second low
// - Receive bus flags: violation and K per byte
// - Receive valid bit 0: one-cycle high-lane start
// - Receive message number updates with valid strobe
// - Receive frame flag bit 0 marks frame start
// - Control messages on own bus and strobe
// - Request strobe one cycle, bit 0 high lane
// - Transmit message number updates with request strobe
// - Transmit frame flag bit 0 marks frame start
// - Message lanes alternate high then low
// - One system clock drives everything
// - Detect boundary idle; replace violations with fill
// - Blocks with any violation are bad; runs counted
// - Groups good only with legal message and idles
package rlsup_pkg;

    // ******************************
    // Register map
    // ******************************
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] DELTA_OFFSET = 12'h004;
    localparam logic [11:0] STATUS_OFFSET = 12'h008;
    localparam int CTRL_TX_ENABLE_BIT = 0;
    localparam int CTRL_LOS_GATE_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [31:0] DELTA_RESET = 32'h0000_0000;
    localparam int STATUS_TX_LSB = 0;
    localparam int STATUS_RX_LSB = 4;
    localparam int STATUS_LOS_BIT = 8;

    // ******************************
    // Line codes and framing
    // ******************************
    localparam logic [7:0] K30_7_BYTE = 8'hfe;
    localparam logic [7:0] K28_5_BYTE = 8'hbc;
    localparam logic [7:0] K28_7_BYTE = 8'hfc;
    localparam int MSG_BYTES = 19;
    localparam logic [4:0] MPOS_LAST = 5'h12;
    localparam logic [7:0] CTL_MSG_INDEX = 8'h00;
    localparam logic [15:0] RUN_MAX = 16'hffff;

    // Byte classes carried down the transmit pipeline
    localparam logic [1:0] CLS_FILL = 2'h0;
    localparam logic [1:0] CLS_K285 = 2'h1;
    localparam logic [1:0] CLS_K287 = 2'h2;
    localparam logic [1:0] CLS_DATA = 2'h3;

    typedef enum logic [2:0] {
        TX_OFF = 3'b001,
        TX_IDLE = 3'b010,
        TX_FRAME = 3'b100
    } rlsup_tx_state_type;

    typedef enum logic [3:0] {
        unsynchronized_state = 4'b0001,
        wait_boundary_idles_state = 4'b0010,
        RX_WAIT_FRAME_SYNC = 4'b0100,
        RX_FRAME_SYNC = 4'b1000
    } rlsup_rx_state_type;

    // Position of one byte within the frame
    typedef struct packed {
        logic [13:0] grp;
        logic [7:0] mig;
        logic [12:0] gpos;
        logic [4:0] mpos;
    } rlsup_pos_type;

endpackage

// *** test/rlsup_link_monitor.sv ***
// Port checker for the link block
`timescale 1ns/1ps
module rlsup_link_monitor (
    // Watched ports
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] tx_lane_data,
    input wire logic [19:0] rx_payload_msg_bus,
    input wire logic [1:0] rx_payload_msg_valid,
    input wire logic [20:0] rx_payload_msg_number,
    input wire logic [1:0] tx_payload_msg_request,
    input wire logic [20:0] tx_payload_msg_number
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_fill_start: assert property ($rose(presetn) |-> tx_lane_data == 16'hfefe)
        else $error("no fill");
    chk_req_hi: assert property (tx_payload_msg_request[0] |=> !tx_payload_msg_request[0])
        else $error("long req");
    chk_req_lo: assert property (tx_payload_msg_request[1] |=> !tx_payload_msg_request[1])
        else $error("long req");
    chk_req_lane: assert property (tx_payload_msg_request != 2'b11)
        else $error("two lanes");
    chk_tx_num: assert property (tx_payload_msg_request == 2'b00 |-> $stable(tx_payload_msg_number))
        else $error("tx number");
    chk_rx_vld: assert property (rx_payload_msg_valid[0] |=> !rx_payload_msg_valid[0])
        else $error("long valid");
    chk_rx_num: assert property (rx_payload_msg_valid == 2'b00 |-> $stable(rx_payload_msg_number))
        else $error("rx number");
    chk_rx_quiet: assert property ($rose(presetn) |->
        (rx_payload_msg_bus == 20'h0_0000 && rx_payload_msg_valid == 2'b00)[*8])
        else $error("early data");
    cover property (tx_payload_msg_request[0]);
    cover property (rx_payload_msg_valid[0]);
    cover property (rx_payload_msg_valid[1]);
endmodule // rlsup_link_monitor
bind rlsup_link rlsup_link_monitor u_rlsup_link_monitor (.*);

// *** test/rlsup_partner.sv ***
// Far side: user logic answering requests, lane looped back
`timescale 1ns/1ps
module rlsup_partner (
    // Clock and fault control
    input wire logic pclk,
    input wire logic cv_force,
    // Lane
    input wire logic [15:0] tx_lane_data,
    input wire logic [1:0] tx_lane_k,
    output logic [15:0] rx_lane_data,
    output logic [1:0] rx_lane_k,
    output logic [1:0] rx_lane_cv,
    // User port
    input wire logic [1:0] tx_payload_msg_request,
    output logic [17:0] tx_payload_msg_bus,
    output logic tx_msg_supplied
);
    logic [3:0] left = 4'h0;
    logic [7:0] seq = 8'h00;
    assign rx_lane_data = tx_lane_data;
    assign rx_lane_k = tx_lane_k;
    assign rx_lane_cv = {2{cv_force}};
    assign tx_msg_supplied = left != 4'h0;
    // Data bytes with K flags clear; bus scrambled while idle
    assign tx_payload_msg_bus = tx_msg_supplied ? {2'b00, seq, seq} : {2'b11, ~seq, seq};
    always_ff @(posedge pclk) begin
        seq <= seq + 8'h01;
        if (tx_payload_msg_request != 2'b00) begin
            left <= 4'ha;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end
    end
endmodule // rlsup_partner

// *** test/rlsup_link_bench.sv ***
// Bench for the link block
`timescale 1ns/1ps
module rlsup_link_bench;
    import rlsup_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, loss_of_signal, cv_force, er;
    logic tx_msg_supplied;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] rx_lane_data, tx_lane_data;
    logic [1:0] rx_lane_k, rx_lane_cv, tx_lane_k, rx_payload_msg_valid, rx_frame_start_flag;
    logic [1:0] rx_ctl_msg_valid, tx_payload_msg_request, tx_frame_start_flag;
    logic [19:0] rx_payload_msg_bus, rx_ctl_msg_bus;
    logic [20:0] rx_payload_msg_number, tx_payload_msg_number;
    logic [17:0] tx_payload_msg_bus;
    int miscompares = 0, n_checks = 0;
    rlsup_link u_rlsup_link (.*);
    rlsup_partner u_rlsup_partner (.*);
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic st(input logic [31:0] exp);
        apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
        chk(rd & 32'h0000_01ff, exp);
    endtask
    task automatic poll_rx(input logic [3:0] v);
        repeat (400) begin
            apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
            if (rd[7:4] === v) break;
        end
    endtask
    task automatic rst;
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic conclude;
        if (miscompares == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        miscompares++;
        conclude();
    end
    initial begin
        {psel, penable, pwrite, loss_of_signal, cv_force} <= 5'h00;
        {paddr, pwdata} <= 44'h000_0000_0000;
        rst();
        st(32'h0000_0011);
        chk({16'h0000, tx_lane_data}, 32'h0000_fefe);
        apb(1'b0, 12'hffc, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk({31'h0000_0000, er}, 32'h0000_0001);
        apb(1'b1, CTRL_OFFSET, 32'h0000_0003);
        st(32'h0000_0011);
        loss_of_signal <= 1'b1;
        st(32'h0000_0112);
        @(posedge pclk);
        chk({16'h0000, tx_lane_data}, 32'h0000_bcbc);
        apb(1'b1, DELTA_OFFSET, 32'h0000_0010);
        st(32'h0000_0114);
        apb(1'b0, DELTA_OFFSET, 32'h0000_0000);
        chk(rd, 32'h0000_0010);
        poll_rx(4'h8);
        st(32'h0000_0184);
        repeat (300) begin
            @(posedge pclk);
            if (rx_frame_start_flag[0] === 1'b1) break;
        end
        chk({30'h0000_0000, rx_ctl_msg_valid}, 32'h0000_0001);
        repeat (300) begin
            @(posedge pclk);
            if (rx_payload_msg_valid[0] === 1'b1) break;
        end
        chk({26'h000_0000, rx_payload_msg_valid, rx_payload_msg_bus[19:16]}, 32'h0000_0010);
        chk({11'h000, rx_payload_msg_number}, 32'h0000_0001);
        repeat (300) begin
            @(posedge pclk);
            if (tx_frame_start_flag[0] === 1'b1) break;
        end
        repeat (30) begin
            @(posedge pclk);
            if (tx_payload_msg_request[0] === 1'b1) break;
        end
        chk({11'h000, tx_payload_msg_number}, 32'h0000_0001);
        cv_force <= 1'b1;
        poll_rx(4'h1);
        st(32'h0000_0114);
        apb(1'b1, CTRL_OFFSET, 32'h0000_0000);
        st(32'h0000_0111);
        cv_force <= 1'b0;
        rst();
        st(32'h0000_0111);
        conclude();
    end
endmodule // rlsup_link_bench
